// *** pkg/cat_pkg.sv ***
// Purpose: shared types and constants for the core addressing and timing decoder
// Assumes: one core clock, 8-bit data, 16-bit code and pointer addresses
// Notes:   opcode encodings follow the standard 8-bit core instruction map
package cat_pkg;

  // operand spaces that an instruction can reach
  typedef enum logic [2:0] {
    CAT_SP_NONE         = 3'b000,
    CAT_SP_IRAM         = 3'b001,
    CAT_SP_SPECIAL_REG  = 3'b010,
    CAT_SP_EXTENDED_RAM = 3'b011,
    CAT_SP_CODE         = 3'b100
  } cat_space_e;

  // operand addressing modes
  typedef enum logic [3:0] {
    CAT_M_NONE     = 4'b0000,
    CAT_M_IMM      = 4'b0001,
    CAT_M_DIRECT   = 4'b0010,
    CAT_M_REG      = 4'b0011,
    CAT_M_INDIRECT = 4'b0100,
    CAT_M_EXT_DIR  = 4'b0101,
    CAT_M_EXT_IND  = 4'b0110,
    CAT_M_CODE_DP  = 4'b0111,
    CAT_M_CODE_PC  = 4'b1000,
    CAT_M_JMP_DP   = 4'b1001
  } cat_mode_e;

  typedef enum logic {
    CAT_ST_IDLE = 1'b0,
    CAT_ST_EXEC = 1'b1
  } cat_state_e;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand;
  } cat_instr_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    cat_space_e space;
    logic [15:0] addr;
  } cat_access_s;

  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cycles;
  } cat_timing_s;

  // address map
  localparam int          HALF_BIT    = 7;
  localparam logic [7:0]  EXT_RAM_HI  = 8'h00;
  localparam logic [15:0] IMM_OFFSET  = 16'h0001;

  // instruction lengths and core clock cycle counts
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;
  localparam logic [3:0] CYC_9 = 4'h9;

  // opcode groups by high nibble, operand form by low nibble
  localparam logic [3:0] HI_INC  = 4'h0;
  localparam logic [3:0] HI_DEC  = 4'h1;
  localparam logic [3:0] HI_ADD  = 4'h2;
  localparam logic [3:0] HI_ADDC = 4'h3;
  localparam logic [3:0] HI_ORL  = 4'h4;
  localparam logic [3:0] HI_ANL  = 4'h5;
  localparam logic [3:0] HI_XRL  = 4'h6;
  localparam logic [3:0] HI_SUBB = 4'h9;
  localparam logic [3:0] HI_MOVA = 4'he;
  localparam logic [3:0] LO_DIRA = 4'h2;
  localparam logic [3:0] LO_DIRI = 4'h3;
  localparam logic [3:0] LO_IMM  = 4'h4;
  localparam logic [3:0] LO_DIR  = 4'h5;

  localparam logic [7:0] OP_MUL      = 8'ha4;
  localparam logic [7:0] OP_DIV      = 8'h84;
  localparam logic [7:0] OP_DA       = 8'hd4;
  localparam logic [7:0] OP_INC_DP   = 8'ha3;
  localparam logic [7:0] OP_MOV_AIMM = 8'h74;
  localparam logic [7:0] OP_MOV_DP   = 8'h90;
  localparam logic [7:0] OP_XRD_DP   = 8'he0;
  localparam logic [7:0] OP_XWR_DP   = 8'hf0;
  localparam logic [6:0] OP_XRD_RI   = 7'h71;
  localparam logic [6:0] OP_XWR_RI   = 7'h79;
  localparam logic [7:0] OP_CODE_DP  = 8'h93;
  localparam logic [7:0] OP_CODE_PC  = 8'h83;
  localparam logic [7:0] OP_JMP_DP   = 8'h73;

endpackage

// *** rtl/cat_addr_res.sv ***
// Purpose: resolve an operand to its memory space and address
// Assumes: ri_value is the content of the pointer register named by the opcode
// Notes:   purely combinational; extended space is only ever on chip
`timescale 1ns/100ps
`default_nettype none
module cat_addr_res (
  input  wire cat_pkg::cat_mode_e  mode,
  input  wire cat_pkg::cat_instr_s instr,
  input  wire logic [7:0]          acc,
  input  wire logic [15:0]         data_pointer,
  input  wire logic [15:0]         pc,
  input  wire logic [7:0]          ri_value,
  input  wire logic [1:0]          bank,
  output cat_pkg::cat_access_s     access
);
  import cat_pkg::*;

  always_comb begin
    access       = '{valid: 1'b1, write: 1'b0, space: CAT_SP_NONE, addr: 16'h0000};
    access.write = instr.opcode[4];
    case (mode)
      CAT_M_IMM: begin
        access.space = CAT_SP_CODE;
        access.write = 1'b0;
        access.addr  = pc + IMM_OFFSET;
      end
      CAT_M_DIRECT: begin
        access.space = instr.operand[HALF_BIT] ? CAT_SP_SPECIAL_REG : CAT_SP_IRAM;
        access.addr  = {8'h00, instr.operand};
      end
      CAT_M_REG: begin
        access.space = CAT_SP_IRAM;
        access.addr  = {11'h000, bank, instr.opcode[2:0]};
      end
      CAT_M_INDIRECT: begin
        // indirect never reaches the special registers
        access.space = CAT_SP_IRAM;
        access.addr  = {8'h00, ri_value};
      end
      CAT_M_EXT_DIR: begin
        access.space = CAT_SP_EXTENDED_RAM;
        access.addr  = {EXT_RAM_HI, data_pointer[7:0]};
      end
      CAT_M_EXT_IND: begin
        access.space = CAT_SP_EXTENDED_RAM;
        access.addr  = {EXT_RAM_HI, ri_value};
      end
      CAT_M_CODE_DP, CAT_M_JMP_DP: begin
        access.space = CAT_SP_CODE;
        access.write = 1'b0;
        access.addr  = data_pointer + {8'h00, acc};
      end
      CAT_M_CODE_PC: begin
        access.space = CAT_SP_CODE;
        access.write = 1'b0;
        access.addr  = pc + {8'h00, acc};
      end
      default: begin
        access.valid = 1'b0;
        access.write = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// *** rtl/cat_core_decode.sv ***
// Purpose: operand address decode and per-instruction cycle timing of the core
// Assumes: one clock, synchronous active-high reset, inputs synchronous to clk
// Notes:   an instruction is taken when instr_valid and fetch_ok are both high with ce
//
// Behaviour
// - direct address 0x80..0xFF selects special function registers
// - indirect address 0x80..0xFF selects upper internal RAM, never special registers
// - addresses 0x00..0x7F reach same internal RAM direct or indirect
// - extended moves reach only the 256-byte on-chip extended RAM
// - extended direct takes address from data pointer, four cycles
// - extended indirect takes address from working register, one byte, four cycles
// - both extended forms reach every extended RAM location
// - code reads fetch at accumulator plus data pointer or program counter, four cycles
// - accumulator is unsigned index; indirect jump through data pointer takes three cycles
// - immediates follow opcode; move immediate 2/2, load data pointer 3/3
// - register moves 1 cycle, internal memory 2, multiply and divide 9
// - most instructions finish in one or two cycles, back to back
// - add, add-carry, subtract: register 1/1, indirect 1/2, direct or immediate 2/2
// - increment/decrement 1 cycle register, 2 memory; data pointer increment 3
// - logic ops register 1 cycle; direct with accumulator 2/2, immediate to accumulator 2/2, immediate to direct 3/3
// - clear, complement, swap, rotate 1/1; decimal adjust 2 cycles
// - special registers reachable only by direct addressing in upper half
`timescale 1ns/100ps
`default_nettype none
module cat_core_decode #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 16
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                instr_valid,
  input  wire cat_pkg::cat_instr_s instr,
  input  wire logic [7:0]          acc,
  input  wire logic [15:0]         data_pointer,
  input  wire logic [15:0]         pc,
  input  wire logic [7:0]          ri_value,
  input  wire logic [1:0]          bank,
  output cat_pkg::cat_access_s     access_ff,
  output cat_pkg::cat_timing_s     timing_ff,
  output logic                     fetch_ok_ff,
  output logic                     busy_ff,
  output logic                     done_ff
);
  import cat_pkg::*;

  // the datapath is fixed at an 8-bit core with 16-bit pointers
  if (DATA_W != 8 || ADDR_W != 16) begin : g_bad_width
    $error("cat_core_decode supports only DATA_W 8 and ADDR_W 16");
  end

  cat_mode_e   dec_mode;
  cat_timing_s dec_timing;
  cat_access_s dec_access;
  cat_state_e  state_ff;
  logic [3:0]  remain_ff;
  logic        take;
  logic [3:0]  since_ff;

  cat_opclass u_opclass (
    .opcode (instr.opcode),
    .mode   (dec_mode),
    .timing (dec_timing)
  );

  cat_addr_res u_addr_res (
    .mode         (dec_mode),
    .instr        (instr),
    .acc          (acc),
    .data_pointer (data_pointer),
    .pc           (pc),
    .ri_value     (ri_value),
    .bank         (bank),
    .access       (dec_access)
  );

  // a one-cycle instruction leaves fetch_ok high so the next one can follow at once
  assign take = ce && instr_valid && fetch_ok_ff;

  // operand access and timing of the instruction taken
  always_ff @(posedge clk) begin
    if (rst) begin
      access_ff <= '{valid: 1'b0, write: 1'b0, space: CAT_SP_NONE, addr: 16'h0000};
      timing_ff <= '{bytes: LEN_1, cycles: CYC_1};
    end else if (take) begin
      access_ff <= dec_access;
      timing_ff <= dec_timing;
    end
  end

  // cycle count state machine
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff    <= CAT_ST_IDLE;
      remain_ff   <= 4'h0;
      fetch_ok_ff <= 1'b1;
      busy_ff     <= 1'b0;
    end else if (ce) begin
      case (state_ff)
        CAT_ST_IDLE: begin
          if (take) begin
            remain_ff <= dec_timing.cycles - CYC_1;
            if (dec_timing.cycles != CYC_1) begin
              state_ff    <= CAT_ST_EXEC;
              fetch_ok_ff <= 1'b0;
              busy_ff     <= 1'b1;
            end
          end
        end
        CAT_ST_EXEC: begin
          if (remain_ff == CYC_1) begin
            state_ff    <= CAT_ST_IDLE;
            remain_ff   <= 4'h0;
            fetch_ok_ff <= 1'b1;
            busy_ff     <= 1'b0;
          end else begin
            remain_ff <= remain_ff - CYC_1;
          end
        end
        default: begin
          state_ff    <= CAT_ST_IDLE;
          fetch_ok_ff <= 1'b1;
          busy_ff     <= 1'b0;
        end
      endcase
    end
  end

  // pulse on the last cycle of every instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else if (ce) begin
      done_ff <= (take && dec_timing.cycles == CYC_1) ||
                 (state_ff == CAT_ST_EXEC && remain_ff == CYC_1);
    end
  end

  // helper: cycles elapsed since the instruction was taken, only for checking
  always_ff @(posedge clk) begin
    if (rst) begin
      since_ff <= 4'h0;
    end else if (ce) begin
      if (take) begin
        since_ff <= CYC_1;
      end else if (!fetch_ok_ff) begin
        since_ff <= since_ff + CYC_1;
      end
    end
  end

  direct_special_a: assert property (@(posedge clk) disable iff (rst)
    take && dec_mode == CAT_M_DIRECT && instr.operand[HALF_BIT]
    |=> access_ff.space == CAT_SP_SPECIAL_REG && access_ff.addr[7:0] == $past(instr.operand))
    else $error("direct upper-half operand did not select special registers");

  ind_upper_a: assert property (@(posedge clk) disable iff (rst)
    take && dec_mode == CAT_M_INDIRECT
    |=> access_ff.space == CAT_SP_IRAM && access_ff.addr[7:0] == $past(ri_value))
    else $error("indirect operand did not reach internal RAM at pointer");

  low_half_a: assert property (@(posedge clk) disable iff (rst)
    take && ((dec_mode == CAT_M_DIRECT && !instr.operand[HALF_BIT]) ||
             (dec_mode == CAT_M_INDIRECT && !ri_value[HALF_BIT]))
    |=> access_ff.space == CAT_SP_IRAM && !access_ff.addr[HALF_BIT])
    else $error("lower-half operand did not reach internal RAM");

  special_only_a: assert property (@(posedge clk) disable iff (rst)
    access_ff.space == CAT_SP_SPECIAL_REG |->
    access_ff.addr[HALF_BIT] && access_ff.addr[15:8] == 8'h00)
    else $error("special register access outside upper half");

  ext_onchip_a: assert property (@(posedge clk) disable iff (rst)
    access_ff.space == CAT_SP_EXTENDED_RAM |-> access_ff.addr[15:8] == EXT_RAM_HI)
    else $error("extended access left the on-chip extended RAM");

  ext_pointer_a: assert property (@(posedge clk) disable iff (rst)
    take && dec_mode == CAT_M_EXT_DIR
    |=> access_ff.addr[7:0] == $past(data_pointer[7:0]) && timing_ff.cycles == CYC_4
        ##1 !fetch_ok_ff ##1 !fetch_ok_ff)
    else $error("extended direct address or timing wrong");

  ext_register_a: assert property (@(posedge clk) disable iff (rst)
    take && dec_mode == CAT_M_EXT_IND
    |=> access_ff.addr[7:0] == $past(ri_value) && timing_ff.bytes == LEN_1 &&
        timing_ff.cycles == CYC_4)
    else $error("extended indirect address or timing wrong");

  ext_cover_a: assert property (@(posedge clk) disable iff (rst)
    take && (dec_mode == CAT_M_EXT_DIR || dec_mode == CAT_M_EXT_IND)
    |=> access_ff.space == CAT_SP_EXTENDED_RAM && access_ff.valid)
    else $error("extended access not mapped to extended RAM");

  code_index_a: assert property (@(posedge clk) disable iff (rst)
    take && (dec_mode == CAT_M_CODE_DP || dec_mode == CAT_M_CODE_PC)
    |=> access_ff.space == CAT_SP_CODE && timing_ff.cycles == CYC_4 &&
        access_ff.addr == ($past(dec_mode) == CAT_M_CODE_DP ?
                           $past(data_pointer) + {8'h00, $past(acc)} :
                           $past(pc) + {8'h00, $past(acc)}))
    else $error("code-indirect address or timing wrong");

  jmp_ind_a: assert property (@(posedge clk) disable iff (rst)
    take && dec_mode == CAT_M_JMP_DP
    |=> timing_ff.cycles == CYC_3 &&
        access_ff.addr == $past(data_pointer) + {8'h00, $past(acc)})
    else $error("indirect jump target or timing wrong");

  imm_fetch_a: assert property (@(posedge clk) disable iff (rst)
    take && dec_mode == CAT_M_IMM
    |=> access_ff.space == CAT_SP_CODE && access_ff.addr == $past(pc) + IMM_OFFSET &&
        timing_ff.bytes == timing_ff.cycles[1:0])
    else $error("immediate operand not taken after opcode");

  muldiv_a: assert property (@(posedge clk) disable iff (rst)
    take && (instr.opcode == OP_MUL || instr.opcode == OP_DIV)
    |=> timing_ff.cycles == CYC_9 && timing_ff.bytes == LEN_1)
    else $error("multiply or divide not nine cycles");

  arith_a: assert property (@(posedge clk) disable iff (rst)
    take && (instr.opcode[7:4] == HI_ADD || instr.opcode[7:4] == HI_ADDC ||
             instr.opcode[7:4] == HI_SUBB) && instr.opcode[3:0] >= LO_IMM
    |=> timing_ff.cycles == ($past(instr.opcode[3]) ? CYC_1 : CYC_2) &&
        timing_ff.bytes == ($past(instr.opcode[3:1]) == 3'h2 ? LEN_2 : LEN_1))
    else $error("arithmetic length or timing wrong");

  incdp_a: assert property (@(posedge clk) disable iff (rst)
    take && instr.opcode == OP_INC_DP |=> timing_ff.cycles == CYC_3 ##1 !fetch_ok_ff)
    else $error("data pointer increment not three cycles");

  logic_dir_a: assert property (@(posedge clk) disable iff (rst)
    take && (instr.opcode[7:4] == HI_ANL || instr.opcode[7:4] == HI_ORL ||
             instr.opcode[7:4] == HI_XRL) && instr.opcode[3:0] == LO_DIRI
    |=> timing_ff.bytes == LEN_3 && timing_ff.cycles == CYC_3)
    else $error("logic op with immediate to direct byte not 3/3");

  da_a: assert property (@(posedge clk) disable iff (rst)
    take && instr.opcode == OP_DA |=> timing_ff.cycles == CYC_2 && !fetch_ok_ff)
    else $error("decimal adjust not two cycles");

  hold_fetch_a: assert property (@(posedge clk) disable iff (rst)
    // a reset cut into a long instruction raises the flag with no count behind it
    $rose(fetch_ok_ff) && !$past(rst) |-> since_ff == timing_ff.cycles && busy_ff == 1'b0)
    else $error("fetch released after wrong number of cycles");

  one_cycle_a: assert property (@(posedge clk) disable iff (rst)
    take && dec_timing.cycles == CYC_1 |=> fetch_ok_ff && done_ff)
    else $error("one-cycle instruction stalled the next fetch");

endmodule
`default_nettype wire

// *** rtl/cat_opclass.sv ***
// Purpose: classify an opcode into addressing mode, byte length and cycle count
// Assumes: purely combinational; opcodes outside this block's scope read as 1 byte, 1 cycle
// Notes:   arithmetic and logic groups share one low-nibble operand pattern
`timescale 1ns/100ps
`default_nettype none
module cat_opclass (
  input  wire logic [7:0]          opcode,
  output cat_pkg::cat_mode_e       mode,
  output cat_pkg::cat_timing_s     timing
);
  import cat_pkg::*;

  logic [3:0] hi;
  logic [3:0] lo;
  logic       grp_arith;
  logic       grp_logic;
  logic       grp_incdec;

  assign hi         = opcode[7:4];
  assign lo         = opcode[3:0];
  assign grp_logic  = (hi == HI_ORL) || (hi == HI_ANL) || (hi == HI_XRL);
  assign grp_arith  = (hi == HI_ADD) || (hi == HI_ADDC) || (hi == HI_SUBB) || grp_logic;
  assign grp_incdec = (hi == HI_INC) || (hi == HI_DEC);

  always_comb begin
    mode   = CAT_M_NONE;
    timing = '{bytes: LEN_1, cycles: CYC_1};
    if ((grp_arith || grp_incdec || hi == HI_MOVA) && lo[3]) begin
      mode   = CAT_M_REG;
      timing = '{bytes: LEN_1, cycles: CYC_1};
    end else if ((grp_arith || grp_incdec || hi == HI_MOVA) && lo[3:1] == 3'h3) begin
      mode   = CAT_M_INDIRECT;
      timing = '{bytes: LEN_1, cycles: CYC_2};
    end else if ((grp_arith || grp_incdec || hi == HI_MOVA) && lo == LO_DIR) begin
      mode   = CAT_M_DIRECT;
      timing = '{bytes: LEN_2, cycles: CYC_2};
    end else if (grp_arith && lo == LO_IMM) begin
      mode   = CAT_M_IMM;
      timing = '{bytes: LEN_2, cycles: CYC_2};
    end else if (grp_logic && lo == LO_DIRA) begin
      mode   = CAT_M_DIRECT;
      timing = '{bytes: LEN_2, cycles: CYC_2};
    end else if (grp_logic && lo == LO_DIRI) begin
      mode   = CAT_M_DIRECT;
      timing = '{bytes: LEN_3, cycles: CYC_3};
    end else if (opcode == OP_MUL || opcode == OP_DIV) begin
      timing = '{bytes: LEN_1, cycles: CYC_9};
    end else if (opcode == OP_DA) begin
      timing = '{bytes: LEN_1, cycles: CYC_2};
    end else if (opcode == OP_INC_DP) begin
      timing = '{bytes: LEN_1, cycles: CYC_3};
    end else if (opcode == OP_MOV_AIMM) begin
      mode   = CAT_M_IMM;
      timing = '{bytes: LEN_2, cycles: CYC_2};
    end else if (opcode == OP_MOV_DP) begin
      mode   = CAT_M_IMM;
      timing = '{bytes: LEN_3, cycles: CYC_3};
    end else if (opcode == OP_XRD_DP || opcode == OP_XWR_DP) begin
      mode   = CAT_M_EXT_DIR;
      timing = '{bytes: LEN_1, cycles: CYC_4};
    end else if (opcode[7:1] == OP_XRD_RI || opcode[7:1] == OP_XWR_RI) begin
      mode   = CAT_M_EXT_IND;
      timing = '{bytes: LEN_1, cycles: CYC_4};
    end else if (opcode == OP_CODE_DP) begin
      mode   = CAT_M_CODE_DP;
      timing = '{bytes: LEN_1, cycles: CYC_4};
    end else if (opcode == OP_CODE_PC) begin
      mode   = CAT_M_CODE_PC;
      timing = '{bytes: LEN_1, cycles: CYC_4};
    end else if (opcode == OP_JMP_DP) begin
      mode   = CAT_M_JMP_DP;
      timing = '{bytes: LEN_1, cycles: CYC_3};
    end
  end

endmodule
`default_nettype wire

// *** tb/cat_core_decode_bench.sv ***
// Purpose: self-checking bench for the addressing and timing decoder
// Assumes: inputs driven on the falling edge, one take at a time
// Notes:   expected values come from the address map and cycle counts
`timescale 1ns/100ps
`default_nettype none
module cat_core_decode_bench;
  import cat_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, instr_valid = 1'b0;
  cat_instr_s  instr = '0;
  logic [7:0]  acc = 8'h00, ri_value = 8'h00, wdata = 8'h00, rdata;
  logic [15:0] data_pointer = 16'h0000, pc = 16'h0000;
  logic [1:0]  bank = 2'h0;
  cat_access_s access_ff;
  cat_timing_s timing_ff;
  logic        fetch_ok_ff, busy_ff, done_ff;
  int          n_errors = 0, tests_run = 0;
  logic [7:0]  edge_addr [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
  logic [15:0] tbl [31] = '{16'h2811, 16'h2612, 16'h2522, 16'h2422, 16'h3811, 16'h3712,
    16'h3522, 16'h3422, 16'h9811, 16'h9612, 16'h9522, 16'h9422, 16'h0411, 16'h0f11,
    16'h0612, 16'h0522, 16'ha313, 16'h1411, 16'h1811, 16'h1712, 16'h1522, 16'ha419,
    16'h8419, 16'hd412, 16'h5811, 16'h5522, 16'h5333, 16'h4333, 16'h6612, 16'h9033,
    16'he811};
  logic [7:0]  one_cyc [7] = '{8'he4, 8'hf4, 8'hc4, 8'h23, 8'h03, 8'h33, 8'h13};

  always #25 clk = ~clk;

  cat_core_decode dut (.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
    .instr(instr), .acc(acc), .data_pointer(data_pointer), .pc(pc), .ri_value(ri_value),
    .bank(bank), .access_ff(access_ff), .timing_ff(timing_ff), .fetch_ok_ff(fetch_ok_ff),
    .busy_ff(busy_ff), .done_ff(done_ff));
  cat_mem_model mem (.clk(clk), .access(access_ff), .wdata(wdata), .rdata(rdata));

  task automatic give_verdict;
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask

  function automatic cat_access_s ax(input logic w, input cat_space_e sp, input logic [15:0] a);
    return '{1'b1, w, sp, a};
  endfunction

  task automatic wait_ok(output int n);
    for (n = 0; n < 20 && fetch_ok_ff !== 1'b1; n++) @(negedge clk);
    if (fetch_ok_ff !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
  endtask

  // one take, then the hold time and the end pulse are judged
  task automatic issue(input logic [7:0] op, input logic [7:0] opd, input logic [5:0] exp);
    int n;
    instr = '{op, opd};
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    chk("timing", timing_ff, exp);
    wait_ok(n);
    chk("hold", n, exp[3:0] - 4'h1);
    chk("done", done_ff, 1'b1);
    // one idle edge, so valid never falls and rises in the same step
    @(negedge clk);
  endtask

  task automatic t_reset;
    chk("rst access", access_ff, 0);
    chk("rst timing", timing_ff, 6'h11);
    chk("rst flags", {fetch_ok_ff, busy_ff, done_ff}, 3'b100);
  endtask

  task automatic t_direct_indirect;
    for (int i = 0; i < 4; i++) begin
      issue(8'he5, edge_addr[i], 6'h22);
      chk("direct", access_ff, ax(1'b0, edge_addr[i][7] ? CAT_SP_SPECIAL_REG : CAT_SP_IRAM,
        {8'h00, edge_addr[i]}));
      ri_value = edge_addr[i];
      issue(8'he6, 8'h00, 6'h12);
      chk("indirect", access_ff, ax(1'b0, CAT_SP_IRAM, {8'h00, edge_addr[i]}));
    end
  endtask

  task automatic t_reg_imm;
    bank = 2'h2;
    issue(8'h2d, 8'h00, 6'h11);
    chk("reg", access_ff, ax(1'b0, CAT_SP_IRAM, 16'h0015));
    pc = 16'h1234;
    issue(8'h24, 8'h5a, 6'h22);
    chk("imm", access_ff, ax(1'b0, CAT_SP_CODE, 16'h1235));
    pc = 16'hffff;
    issue(OP_MOV_AIMM, 8'h11, 6'h22);
    chk("imm wrap", access_ff, ax(1'b0, CAT_SP_CODE, 16'h0000));
  endtask

  task automatic t_extended_ram;
    data_pointer = 16'h12ab;
    wdata = 8'h5a;
    issue(OP_XWR_DP, 8'h00, 6'h14);
    chk("x dp", access_ff, ax(1'b1, CAT_SP_EXTENDED_RAM, 16'h00ab));
    ri_value = 8'hab;
    issue(8'he3, 8'h00, 6'h14);
    chk("x ri", access_ff, ax(1'b0, CAT_SP_EXTENDED_RAM, 16'h00ab));
    chk("x data", rdata, 8'h5a);
    ri_value = 8'hff;
    issue(8'hf2, 8'h00, 6'h14);
    chk("x ri top", access_ff, ax(1'b1, CAT_SP_EXTENDED_RAM, 16'h00ff));
    data_pointer = 16'hff00;
    issue(OP_XRD_DP, 8'h00, 6'h14);
    chk("x dp low", access_ff, ax(1'b0, CAT_SP_EXTENDED_RAM, 16'h0000));
  endtask

  task automatic t_code;
    acc = 8'hff;
    data_pointer = 16'hfffe;
    issue(OP_CODE_DP, 8'h00, 6'h14);
    chk("code dp", access_ff, ax(1'b0, CAT_SP_CODE, 16'h00fd));
    chk("code data", rdata, 8'hfd);
    acc = 8'h80;
    issue(OP_CODE_PC, 8'h00, 6'h14);
    chk("code pc", access_ff, ax(1'b0, CAT_SP_CODE, 16'h007f));
    issue(OP_JMP_DP, 8'h00, 6'h13);
    chk("jump dp", access_ff, ax(1'b0, CAT_SP_CODE, 16'h007e));
  endtask

  task automatic t_table;
    for (int i = 0; i < 31; i++) issue(tbl[i][15:8], 8'h30, tbl[i][5:0]);
    for (int i = 0; i < 7; i++) issue(one_cyc[i], 8'h30, 6'h11);
  endtask

  // a request held through a long instruction must wait out all nine cycles
  task automatic t_hold_ce;
    int n;
    instr = '{OP_MUL, 8'h00};
    instr_valid = 1'b1;
    @(negedge clk);
    instr = '{OP_MOV_AIMM, 8'h00};
    for (int i = 1; i < 9; i++) begin
      @(negedge clk);
      chk("refused", {busy_ff, timing_ff}, {i < 8, 6'h19});
    end
    @(negedge clk);
    chk("next take", timing_ff, 6'h22);
    ce = 1'b0;
    instr = '{OP_DIV, 8'h00};
    repeat (3) @(negedge clk);
    chk("ce frozen", {busy_ff, timing_ff}, 7'h62);
    ce = 1'b1;
    // one edge to finish the two-cycle move, the next one takes the divide
    repeat (2) @(negedge clk);
    chk("ce take", timing_ff, 6'h19);
    instr_valid = 1'b0;
    wait_ok(n);
    chk("div hold", n, 8);
  endtask

  // a one-edge reset with the enable low must still cut a long instruction
  task automatic t_mid_reset;
    instr = '{OP_MUL, 8'h00};
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    ce = 1'b0;
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    ce = 1'b1;
    t_reset();
  endtask

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_direct_indirect();
    t_reg_imm();
    t_extended_ram();
    t_code();
    t_table();
    t_mid_reset();
    t_hold_ce();
    give_verdict();
  end
endmodule
`default_nettype wire

// *** tb/cat_mem_model.sv ***
// Purpose: behavioural internal RAM, special register, extended RAM and code store
// Assumes: follows the decoder's registered access and returns the selected byte
// Notes:   unselected reads show a toggling pattern so stale data is never trusted
`timescale 1ns/100ps
`default_nettype none
module cat_mem_model #(
  parameter int CODE_DEPTH = 16384
) (
  input  wire logic                 clk,
  input  wire cat_pkg::cat_access_s access,
  input  wire logic [7:0]           wdata,
  output logic [7:0]                rdata
);
  import cat_pkg::*;
  logic [7:0] iram_mem    [256];
  logic [7:0] special_mem [128];
  logic [7:0] ext_ram_mem [256];
  logic       idle_ff = 1'b0;

  always_ff @(posedge clk) begin
    idle_ff <= ~idle_ff;
    if (access.valid && access.write) begin
      case (access.space)
        CAT_SP_IRAM:         iram_mem[access.addr[7:0]]    <= wdata;
        CAT_SP_SPECIAL_REG:  special_mem[access.addr[6:0]] <= wdata;
        CAT_SP_EXTENDED_RAM: ext_ram_mem[access.addr[7:0]] <= wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (access.space)
      CAT_SP_IRAM:         rdata = iram_mem[access.addr[7:0]];
      CAT_SP_SPECIAL_REG:  rdata = special_mem[access.addr[6:0]];
      CAT_SP_EXTENDED_RAM: rdata = ext_ram_mem[access.addr[7:0]];
      CAT_SP_CODE: begin
        // code pattern is a function of address so a wrong index shows
        if (int'(access.addr) < CODE_DEPTH) rdata = access.addr[7:0] ^ access.addr[15:8];
        else rdata = {4{idle_ff, ~idle_ff}};
      end
      default: rdata = {4{idle_ff, ~idle_ff}};
    endcase
  end
endmodule
`default_nettype wire
